// *** verilog/ncm_ctrl.sv ***
// Purpose: phase/time accumulators, table addressing and cmac control
// Assumes: control pins come from logic on pclk; tables are external
// Notes:   control pins registered once before acting, except phase_carry_in_n which acts unregistered
//
// Behaviour
// - low enable loads interval register
// - low enable captures both vectors
// - half circle clears top address bit
// - offset zeroed, register still loads
// - load zeroes phase feedback
// - quadrant bits step 90 degrees
// - quadrant loads only with phase enable
// - source select: control register or quadrant
// - bypass feeds phase words to multiplier
// - bypass zeroes time feedback
// - low carry in adds one
// - low carry out on phase overflow
// - low carry out on interval overflow
// - real input captured on clock
// - imaginary input captured on clock
// - one shift for both vectors
// - high sums and holds, low dumps
// - low format inverts bit nineteen
// - host writes addressed control register
// - low phase enable loads phase register
// - interval accumulates, overflow drives carry
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "ncm_defines.svh"
module ncm_ctrl
    import ncm_pkg::*;
#(
    parameter int VEC_W  = 19,
    parameter int TRIG_W = 16,
    parameter int ACC_W  = 40,
    parameter int OUT_W  = 20
) (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [`NCM_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // phase and time control pins
    input  wire logic                  phase_reg_en_n,
    input  wire logic                  interval_load_en_n,
    input  wire logic                  half_circle_select,
    input  wire logic                  offset_path_zero_n,
    input  wire logic                  phase_acc_load_n,
    input  wire logic [1:0]            quadrant_offset_bits,
    input  wire logic                  phase_source_select,
    input  wire logic                  table_bypass_interval_load_n,
    input  wire logic                  phase_carry_in_n,
    // cmac control pins
    input  wire logic                  vector_capture_en_n,
    input  wire ncm_shift_t            input_shift_select,
    input  wire logic                  sum_or_dump_select,
    input  wire logic                  offset_binary_select_n,
    // vector and table data
    input  wire logic [VEC_W-1:0]      real_vector_in,
    input  wire logic [VEC_W-1:0]      imag_vector_in,
    input  wire logic [TRIG_W-1:0]     sine_table_in,
    input  wire logic [TRIG_W-1:0]     cosine_table_in,
    // results
    output logic      [TRIG_W-1:0]     table_addr,
    output logic                       phase_carry_out_n,
    output logic                       interval_carry_out_n,
    output logic      [OUT_W-1:0]      real_out,
    output logic      [OUT_W-1:0]      imag_out
);

    localparam int PROD_W = VEC_W + TRIG_W + 1;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // path that a low control forces to zero
    function automatic ncm_word_t word_gate(input logic keep, input ncm_word_t v);
        word_gate = keep ? v : `NCM_RST_WORD;
    endfunction

    // ----------------------------------------
    // sampled control pins
    // ----------------------------------------
    logic       s_phase_en_n;
    logic       s_int_en_n;
    logic       s_half;
    logic       s_off_zero_n;
    logic       s_load_n;
    logic [1:0] s_quad;
    logic       s_src_sel;
    logic       s_bypass_n;
    logic       s_cap_en_n;
    ncm_shift_t s_shift;
    logic       s_sum;
    logic       s_fmt_n;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_phase_en_n <= `NCM_IDLE_N;
            s_int_en_n   <= `NCM_IDLE_N;
            s_half       <= `NCM_IDLE;
            s_off_zero_n <= `NCM_IDLE_N;
            s_load_n     <= `NCM_IDLE_N;
            s_quad       <= 2'h0;
            s_src_sel    <= `NCM_IDLE;
            s_bypass_n   <= `NCM_IDLE_N;
            s_cap_en_n   <= `NCM_IDLE_N;
            s_shift      <= 2'h0;
            s_sum        <= `NCM_IDLE;
            s_fmt_n      <= `NCM_IDLE_N;
        end else begin
            s_phase_en_n <= phase_reg_en_n;
            s_int_en_n   <= interval_load_en_n;
            s_half       <= half_circle_select;
            s_off_zero_n <= offset_path_zero_n;
            s_load_n     <= phase_acc_load_n;
            s_quad       <= quadrant_offset_bits;
            s_src_sel    <= phase_source_select;
            s_bypass_n   <= table_bypass_interval_load_n;
            s_cap_en_n   <= vector_capture_en_n;
            s_shift      <= input_shift_select;
            s_sum        <= sum_or_dump_select;
            s_fmt_n      <= offset_binary_select_n;
        end
    end

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    ncm_word_t center_freq;
    ncm_word_t offset_freq;
    ncm_half_t phase_ctrl;
    ncm_word_t interval_ctrl;
    ncm_word_t phase_acc;
    ncm_word_t time_acc;
    logic      hit_cfreq;
    logic      hit_ofreq;
    logic      hit_phctrl;
    logic      hit_interval;
    logic      hit_phacc;
    logic      hit_timacc;
    logic      hit_any;
    logic      setup_phase;
    logic      write_now;
    ncm_word_t rd_mux;

    assign hit_cfreq    = (paddr == `NCM_OFS_CFREQ);
    assign hit_ofreq    = (paddr == `NCM_OFS_OFREQ);
    assign hit_phctrl   = (paddr == `NCM_OFS_PHCTRL);
    assign hit_interval = (paddr == `NCM_OFS_INTERVAL);
    assign hit_phacc    = (paddr == `NCM_OFS_PHACC);
    assign hit_timacc   = (paddr == `NCM_OFS_TIMACC);
    assign hit_any      = hit_cfreq | hit_ofreq | hit_phctrl | hit_interval | hit_phacc | hit_timacc;
    assign setup_phase  = psel & ~penable;
    // writes land at the access edge
    assign write_now    = psel & penable & pready & pwrite & hit_any;

    assign rd_mux = hit_cfreq    ? center_freq :
                    hit_ofreq    ? offset_freq :
                    hit_phctrl   ? {16'h0000, phase_ctrl} :
                    hit_interval ? interval_ctrl :
                    hit_phacc    ? phase_acc :
                    hit_timacc   ? time_acc : `NCM_RST_WORD;

    // no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= `NCM_IDLE;
            pslverr <= `NCM_IDLE;
            prdata  <= `NCM_RST_WORD;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase & ~hit_any;
            prdata  <= setup_phase ? rd_mux : `NCM_RST_WORD;
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    // offset register loads even while its path is zeroed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            center_freq   <= `NCM_RST_WORD;
            offset_freq   <= `NCM_RST_WORD;
            phase_ctrl    <= `NCM_RST_HALF;
            interval_ctrl <= `NCM_RST_WORD;
        end else if (write_now) begin
            if (hit_cfreq)    center_freq   <= pwdata;
            if (hit_ofreq)    offset_freq   <= pwdata;
            if (hit_phctrl)   phase_ctrl    <= pwdata[15:0];
            if (hit_interval) interval_ctrl <= pwdata;
        end
    end

    // ----------------------------------------
    // phase register
    // ----------------------------------------
    ncm_half_t phase_reg;
    ncm_half_t next_phase_src;

    assign next_phase_src = s_src_sel ? phase_ctrl : {s_quad, `NCM_QUAD_ZERO};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= `NCM_RST_HALF;
        end else if (!s_phase_en_n) begin
            phase_reg <= next_phase_src;
        end
    end

    // ----------------------------------------
    // phase accumulator
    // ----------------------------------------
    ncm_word_t   freq_sum;
    logic [32:0] next_phase_sum;
    ncm_half_t   next_arg;
    ncm_half_t   next_addr;

    assign freq_sum       = center_freq + word_gate(s_off_zero_n, offset_freq);
    assign next_phase_sum = {1'b0, word_gate(s_load_n, phase_acc)}
                          + {1'b0, freq_sum}
                          + {32'h0000_0000, ~phase_carry_in_n};
    assign next_arg       = phase_acc[31:16] + phase_reg;
    // half circle: top address bit held low
    assign next_addr      = s_half ? {`NCM_ADDR_MSB_OFF, next_arg[TRIG_W-2:0]} : next_arg;

    ncm_half_t arg_q;
    ncm_half_t acc_low_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_acc         <= `NCM_RST_WORD;
            phase_carry_out_n <= `NCM_IDLE_N;
            table_addr        <= `NCM_RST_HALF;
            arg_q             <= `NCM_RST_HALF;
            acc_low_q         <= `NCM_RST_HALF;
        end else begin
            phase_acc         <= next_phase_sum[31:0];
            phase_carry_out_n <= ~next_phase_sum[32];
            table_addr        <= next_addr;
            arg_q             <= next_arg;
            acc_low_q         <= phase_acc[15:0];
        end
    end

    // ----------------------------------------
    // time accumulator
    // ----------------------------------------
    ncm_word_t   interval_reg;
    logic [32:0] next_time_sum;

    assign next_time_sum = {1'b0, word_gate(s_bypass_n, time_acc)}
                         + {1'b0, interval_reg};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interval_reg         <= `NCM_RST_WORD;
            time_acc             <= `NCM_RST_WORD;
            interval_carry_out_n <= `NCM_IDLE_N;
        end else begin
            if (!s_int_en_n) begin
                interval_reg <= interval_ctrl;
            end
            time_acc             <= next_time_sum[31:0];
            interval_carry_out_n <= ~next_time_sum[32];
        end
    end

    // ----------------------------------------
    // vector inputs and shifters
    // ----------------------------------------
    logic [VEC_W-1:0] vec_reg [2];
    logic [VEC_W-1:0] vec_sh  [2];
    logic [VEC_W-1:0] vec_in  [2];

    assign vec_in[0] = real_vector_in;
    assign vec_in[1] = imag_vector_in;

    // index 0 real, 1 imaginary
    for (genvar g = 0; g < 2; g++) begin : g_vec
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                vec_reg[g] <= VEC_W'(0);
            end else if (!s_cap_en_n) begin
                vec_reg[g] <= vec_in[g];
            end
        end

        ncm_vec_shift #(
            .VEC_W     (VEC_W)
        ) u_shift (
            .din       (vec_reg[g]),
            .shift_sel (s_shift),
            .dout      (vec_sh[g])
        );
    end

    logic [VEC_W-1:0] real_vector_reg;
    logic [VEC_W-1:0] imag_vector_reg;

    assign real_vector_reg = vec_sh[0];
    assign imag_vector_reg = vec_sh[1];

    // ----------------------------------------
    // complex multiplier
    // ----------------------------------------
    logic signed [TRIG_W-1:0] sin_op;
    logic signed [TRIG_W-1:0] cos_op;
    logic signed [PROD_W-1:0] next_prod_re;
    logic signed [PROD_W-1:0] next_prod_im;
    logic signed [PROD_W-1:0] prod_re;
    logic signed [PROD_W-1:0] prod_im;

    // bypass: raw phase words to the multiplier
    assign sin_op = s_bypass_n ? sine_table_in   : arg_q;
    assign cos_op = s_bypass_n ? cosine_table_in : acc_low_q;

    assign next_prod_re = PROD_W'($signed(real_vector_reg) * cos_op)
                        - PROD_W'($signed(imag_vector_reg) * sin_op);
    assign next_prod_im = PROD_W'($signed(real_vector_reg) * sin_op)
                        + PROD_W'($signed(imag_vector_reg) * cos_op);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prod_re <= PROD_W'(0);
            prod_im <= PROD_W'(0);
        end else begin
            prod_re <= next_prod_re;
            prod_im <= next_prod_im;
        end
    end

    // ----------------------------------------
    // accumulate and dump
    // ----------------------------------------
    logic signed [ACC_W-1:0] acc_re;
    logic signed [ACC_W-1:0] acc_im;
    logic signed [ACC_W-1:0] hold_re;
    logic signed [ACC_W-1:0] hold_im;
    logic signed [ACC_W-1:0] next_acc_re;
    logic signed [ACC_W-1:0] next_acc_im;

    // dump zeroes feedback: fresh sum
    assign next_acc_re = (s_sum ? acc_re : ACC_W'(0)) + ACC_W'(prod_re);
    assign next_acc_im = (s_sum ? acc_im : ACC_W'(0)) + ACC_W'(prod_im);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_re  <= ACC_W'(0);
            acc_im  <= ACC_W'(0);
            hold_re <= ACC_W'(0);
            hold_im <= ACC_W'(0);
        end else begin
            acc_re <= next_acc_re;
            acc_im <= next_acc_im;
            if (!s_sum) begin
                hold_re <= acc_re;
                hold_im <= acc_im;
            end
        end
    end

    // ----------------------------------------
    // output format
    // ----------------------------------------
    logic [OUT_W-1:0] hold_re_slice;
    logic [OUT_W-1:0] hold_im_slice;
    logic             real_out_msb;
    logic             imag_out_msb;

    assign hold_re_slice = hold_re[`NCM_OUT_LSB +: OUT_W];
    assign hold_im_slice = hold_im[`NCM_OUT_LSB +: OUT_W];
    // offset binary for unsigned converters: flip the sign bit
    assign real_out_msb  = hold_re_slice[OUT_W-1] ^ ~s_fmt_n;
    assign imag_out_msb  = hold_im_slice[OUT_W-1] ^ ~s_fmt_n;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            real_out <= `NCM_RST_OUT;
            imag_out <= `NCM_RST_OUT;
        end else begin
            real_out <= {real_out_msb, hold_re_slice[OUT_W-2:0]};
            imag_out <= {imag_out_msb, hold_im_slice[OUT_W-2:0]};
        end
    end

endmodule

// *** verilog/ncm_defines.svh ***
// Purpose: named constants of the nco/cmac block
// Assumes: one 32-bit apb word per register
// Notes:   offsets are byte addresses
`ifndef NCM_DEFINES_SVH
`define NCM_DEFINES_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define NCM_ADDR_W       8
`define NCM_OFS_CFREQ    8'h00
`define NCM_OFS_OFREQ    8'h04
`define NCM_OFS_PHCTRL   8'h08
`define NCM_OFS_INTERVAL 8'h0C
`define NCM_OFS_PHACC    8'h10
`define NCM_OFS_TIMACC   8'h14

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define NCM_QUAD_ZERO    14'h0000
`define NCM_ADDR_MSB_OFF 1'b0
`define NCM_OUT_LSB      15
`define NCM_IDLE_N       1'b1
`define NCM_IDLE         1'b0
`define NCM_RST_WORD     32'h0000_0000
`define NCM_RST_HALF     16'h0000
`define NCM_RST_OUT      20'h0_0000

`endif

// *** verilog/ncm_pkg.sv ***
// Purpose: shared types of the nco/cmac control block
// Assumes: 32-bit phase words, 16-bit phase offsets
// Notes:   constants live in ncm_defines.svh
package ncm_pkg;
    typedef logic [31:0] ncm_word_t;
    typedef logic [15:0] ncm_half_t;
    typedef logic [1:0]  ncm_shift_t;
endpackage

// *** verilog/ncm_vec_shift.sv ***
// Purpose: arithmetic right shifter ahead of the complex multiplier
// Assumes: two's complement input
// Notes:   shift code 0..3 gives 0..3 bits of right shift
`timescale 1ns/10ps
module ncm_vec_shift
    import ncm_pkg::*;
#(
    parameter int VEC_W = 19
) (
    // data
    input  wire logic [VEC_W-1:0] din,
    input  wire ncm_shift_t       shift_sel,
    output wire logic [VEC_W-1:0] dout
);
    // sign bits refill the top so scaling keeps the sign
    assign dout = VEC_W'($signed(din) >>> shift_sel);
endmodule

// *** tb/ncm_ctrl_monitor.sv ***
// Purpose: port checks of the nco/cmac block
// Assumes: one pclk domain, presetn asynchronous active low
// Notes:   bound to ncm_ctrl
`timescale 1ns/10ps
module ncm_ctrl_monitor
    import ncm_pkg::*;
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    // control pins
    input wire logic        half_circle_select,
    input wire logic        phase_acc_load_n,
    input wire logic        phase_carry_in_n,
    input wire logic        table_bypass_interval_load_n,
    input wire logic        sum_or_dump_select,
    input wire logic        offset_binary_select_n,
    // results
    input wire logic [15:0] table_addr,
    input wire logic        phase_carry_out_n,
    input wire logic        interval_carry_out_n,
    input wire logic [19:0] real_out,
    input wire logic [19:0] imag_out
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ----------------------------------------
    // apb answer
    // ----------------------------------------
    chk_setup_gets_ready: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");

    // ----------------------------------------
    // control pin effects
    // ----------------------------------------
    // three cycles: sampling stage plus registered result
    chk_half_circle_msb: assert property (half_circle_select [*3] |=> !table_addr[15])
        else $error("msb high in half circle");
    chk_acc_load_carry: assert property (
        (!phase_acc_load_n && phase_carry_in_n) [*3] |=> phase_carry_out_n)
        else $error("phase carry while loading");
    chk_bypass_no_carry: assert property (
        !table_bypass_interval_load_n [*3] |=> interval_carry_out_n)
        else $error("interval carry while loading");
    chk_hold_stable: assert property (
        (sum_or_dump_select && $stable(offset_binary_select_n)) [*4] |=> $stable(real_out) && $stable(imag_out))
        else $error("output moved while accumulating");

    cov_phase_carry: cover property (!phase_carry_out_n);
    cov_interval_carry: cover property (!interval_carry_out_n);
    cov_slave_error: cover property (pslverr);
endmodule

bind ncm_ctrl ncm_ctrl_monitor u_monitor (.*);

// *** tb/ncm_sample_src.sv ***
// Purpose: complex sample source feeding the vector inputs
// Assumes: samples change just after the rising edge
// Notes:   idle bus toggles
`timescale 1ns/10ps
module ncm_sample_src (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // request
    input  wire logic        present,
    input  wire logic [18:0] re_val,
    input  wire logic [18:0] im_val,
    // vector bus
    output logic      [18:0] real_vector_in,
    output logic      [18:0] imag_vector_in
);
    // idle bus toggles so a stray capture shows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            real_vector_in <= 19'h0_0000;
            imag_vector_in <= 19'h0_0000;
        end else if (present) begin
            real_vector_in <= re_val;
            imag_vector_in <= im_val;
        end else begin
            real_vector_in <= ~real_vector_in;
            imag_vector_in <= ~imag_vector_in;
        end
    end
endmodule

// *** tb/ncm_ctrl_tb.sv ***
// Purpose: bench for the nco/cmac block
// Assumes: apb master in this file
// Notes:   sine 0, cosine one half: outputs scale vectors
`timescale 1ns/10ps
`include "ncm_defines.svh"
module ncm_ctrl_tb
    import ncm_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, present;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready, pslverr, phase_carry_out_n, interval_carry_out_n;
    logic        phase_reg_en_n, interval_load_en_n, half_circle_select, offset_path_zero_n;
    logic        phase_acc_load_n, phase_source_select, table_bypass_interval_load_n;
    logic        phase_carry_in_n, vector_capture_en_n, sum_or_dump_select, offset_binary_select_n;
    logic [1:0]  quadrant_offset_bits;
    ncm_shift_t  input_shift_select;
    logic [18:0] re_val, im_val;
    wire  [18:0] real_vector_in, imag_vector_in;
    wire  [15:0] table_addr;
    wire  [19:0] real_out, imag_out;
    int          err_total, n_tests;

    ncm_ctrl DUT (.*, .sine_table_in(16'h0000), .cosine_table_in(16'h4000));
    ncm_sample_src u_src (.*);

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int i;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i >= 16) begin
            err_total++;
            test_done();
        end
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    // counts low carries or high address msb over 16 settled cycles
    task automatic cnt(input int sel, output logic [31:0] n);
        n = 32'h0000_0000;
        tick(6);
        repeat (16) begin
            @(posedge pclk);
            case (sel)
                0: n += 32'(phase_carry_out_n === 1'b0);
                1: n += 32'(interval_carry_out_n === 1'b0);
                default: n += 32'(table_addr[15] === 1'b1);
            endcase
        end
    endtask

    function automatic logic [31:0] ex(input logic [18:0] v, input int s);
        logic signed [19:0] t;
        t = $signed({v[18], v});
        return {12'h000, t >>> (s + 1)};
    endfunction

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_apb();
        logic [31:0] q;
        logic        e;
        wr(`NCM_OFS_CFREQ, 32'h4000_0000);
        apb(1'b0, `NCM_OFS_CFREQ, 32'h0, q, e);
        check("cfreq", q, 32'h4000_0000);
        wr(`NCM_OFS_PHCTRL, 32'hABCD_1234);
        apb(1'b0, `NCM_OFS_PHCTRL, 32'h0, q, e);
        check("phctrl", q, 32'h0000_1234);
        apb(1'b0, 8'h20, 32'h0, q, e);
        check("unmapped", {q[30:0], e}, 32'h1);
        apb(1'b1, `NCM_OFS_PHACC, 32'hFFFF_FFFF, q, e);
        check("ro_write", {31'h0, e}, 32'h0);
        $display("test apb done");
    endtask

    task automatic t_phase();
        logic [31:0] n, q;
        logic        e;
        wr(`NCM_OFS_OFREQ, 32'h4000_0000);
        cnt(0, n);
        check("phase_carry_out_n_sum", n, 32'd8);
        offset_path_zero_n <= 1'b0;
        cnt(0, n);
        check("phase_carry_out_n_ofs0", n, 32'd4);
        apb(1'b0, `NCM_OFS_OFREQ, 32'h0, q, e);
        check("ofreq_kept", q, 32'h4000_0000);
        wr(`NCM_OFS_OFREQ, 32'h0000_0000);
        offset_path_zero_n <= 1'b1;
        cnt(0, n);
        check("phase_carry_out_n_ofsld", n, 32'd4);
        cnt(2, n);
        check("msb_full", n, 32'd8);
        half_circle_select <= 1'b1;
        cnt(2, n);
        check("msb_half", n, 32'd0);
        half_circle_select <= 1'b0;
        wr(`NCM_OFS_CFREQ, 32'h3FFF_FFFF);
        phase_carry_in_n <= 1'b0;
        cnt(0, n);
        check("phase_carry_out_n_cin", n, 32'd4);
        phase_carry_in_n <= 1'b1;
        wr(`NCM_OFS_CFREQ, 32'h4000_0000);
        phase_acc_load_n <= 1'b0;
        cnt(0, n);
        check("phase_carry_out_n_load", n, 32'd0);
        apb(1'b0, `NCM_OFS_PHACC, 32'h0, q, e);
        check("phacc_load", q, 32'h4000_0000);
        $display("test phase done");
    endtask

    task automatic t_quad();
        wr(`NCM_OFS_CFREQ, 32'h0000_0000);
        phase_source_select <= 1'b0;
        phase_reg_en_n      <= 1'b0;
        for (int q = 0; q < 4; q++) begin
            quadrant_offset_bits <= 2'(q);
            tick(6);
            check("quad", {16'h0, table_addr}, {16'h0, 2'(q), 14'h0});
        end
        phase_reg_en_n       <= 1'b1;
        quadrant_offset_bits <= 2'b01;
        tick(6);
        check("quad_hold", {16'h0, table_addr}, 32'h0000_C000);
        wr(`NCM_OFS_PHCTRL, 32'h0000_1234);
        phase_source_select <= 1'b1;
        phase_reg_en_n      <= 1'b0;
        tick(6);
        check("phsrc_reg", {16'h0, table_addr}, 32'h0000_1234);
        phase_reg_en_n   <= 1'b1;
        phase_acc_load_n <= 1'b1;
        $display("test quadrant done");
    endtask

    task automatic t_time();
        logic [31:0] n, q;
        logic        e;
        wr(`NCM_OFS_INTERVAL, 32'h4000_0000);
        cnt(1, n);
        check("interval_carry_out_n_noload", n, 32'd0);
        interval_load_en_n <= 1'b0;
        cnt(1, n);
        check("interval_carry_out_n_run", n, 32'd4);
        interval_load_en_n           <= 1'b1;
        table_bypass_interval_load_n <= 1'b0;
        cnt(1, n);
        check("interval_carry_out_n_byp", n, 32'd0);
        apb(1'b0, `NCM_OFS_TIMACC, 32'h0, q, e);
        check("timacc_ld", q, 32'h4000_0000);
        table_bypass_interval_load_n <= 1'b1;
        $display("test time done");
    endtask

    task automatic t_vec();
        re_val              <= 19'h0_1000;
        im_val              <= 19'h7_F000;
        present             <= 1'b1;
        vector_capture_en_n <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            input_shift_select <= 2'(s);
            tick(10);
            check("re_sh", {12'h0, real_out}, ex(19'h0_1000, s));
            check("im_sh", {12'h0, imag_out}, ex(19'h7_F000, s));
        end
        offset_binary_select_n <= 1'b0;
        tick(6);
        check("re_fmt", {12'h0, real_out}, ex(19'h0_1000, 3) ^ 32'h8_0000);
        check("im_fmt", {12'h0, imag_out}, ex(19'h7_F000, 3) ^ 32'h8_0000);
        offset_binary_select_n <= 1'b1;
        vector_capture_en_n    <= 1'b1;
        present                <= 1'b0;
        tick(10);
        check("re_nocap", {12'h0, real_out}, ex(19'h0_1000, 3));
        sum_or_dump_select  <= 1'b1;
        present             <= 1'b1;
        re_val              <= 19'h0_2000;
        vector_capture_en_n <= 1'b0;
        tick(10);
        check("re_accum", {12'h0, real_out}, ex(19'h0_1000, 3));
        sum_or_dump_select <= 1'b0;
        tick(10);
        check("re_dump", {12'h0, real_out}, ex(19'h0_2000, 3));
        $display("test vector done");
    endtask

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial begin
        err_total = 0;
        n_tests = 0;
        {presetn, psel, penable, pwrite, present, half_circle_select, sum_or_dump_select} = 7'h00;
        {phase_reg_en_n, interval_load_en_n, offset_path_zero_n, phase_acc_load_n} = 4'hF;
        {phase_source_select, table_bypass_interval_load_n, phase_carry_in_n} = 3'h7;
        {vector_capture_en_n, offset_binary_select_n} = 2'h3;
        quadrant_offset_bits = 2'b00;
        input_shift_select = 2'b00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        re_val = 19'h0_0000;
        im_val = 19'h0_0000;
        tick(5);
        presetn <= 1'b1;
        tick(1);
        t_apb();
        t_phase();
        t_quad();
        t_time();
        t_vec();
        test_done();
    end
endmodule
